// ==== include/fabric_load_pkg.sv ====
/*
 * Constants, register map and types for the link-based fabric loader.
 * Assumes the hardened endpoint core presents config-space accesses to the
 * loading capability as dword indices on CLK_I.
 */
// Functional notes
// - endpoint core runs and trains regardless of mode
// - fabric loading allowed only after link reaches L0
// - loading and application share one fixed link mode
// - I/O ring and core config stay unchanged
// - buffer host data, forward to control block
// - 16-bit status: ready, error, encrypt, decompression
// - 32-bit control register writes start loading events
// - 32-bit data register holds data before forwarding
// - read-only silicon identity register
// - 16-bit user-set board type identity register
// - BARs claimed by loader while loading, else application
// - cold reset drops link, starts no load
// - after loading core goes to application; reload allowed
// - registers sit in vendor-specific extended capability
// - loading off and no user mode: answer retry
// - enable and init bits select the operating mode
package fabric_load_pkg;
    // capability dword indices within the vendor-specific capability
    localparam logic [2:0]  IDX_CAP_HDR    = 3'h0;
    localparam logic [2:0]  IDX_LEN_REV_ID = 3'h1;
    localparam logic [2:0]  IDX_STATUS     = 3'h2;
    localparam logic [2:0]  IDX_CONTROL    = 3'h3;
    localparam logic [2:0]  IDX_DATA       = 3'h4;
    localparam logic [2:0]  IDX_SILICON    = 3'h5;
    localparam logic [2:0]  IDX_BOARD      = 3'h6;

    localparam logic [15:0] CAP_ID_VSEC    = 16'h000B;
    localparam logic [3:0]  CAP_VERSION    = 4'h1;
    localparam logic [11:0] CAP_NEXT       = 12'h000;
    localparam logic [15:0] VSEC_ID        = 16'h0001; // arbitrary value
    localparam logic [3:0]  VSEC_REV       = 4'h1;
    localparam logic [11:0] VSEC_LEN       = 12'h01C;
    localparam logic [31:0] SILICON_ID_DEF = 32'h0000_0001; // arbitrary value

    // control register strobe bits
    localparam int          CTRL_START     = 0;
    localparam int          CTRL_HALT      = 1;
    localparam int          CTRL_ERR_CLR   = 2;
    localparam logic [31:0] CTRL_STROBES   = 32'h0000_0007;

    // status register bits
    localparam int          ST_READY       = 0;
    localparam int          ST_ERROR       = 1;
    localparam int          ST_USER        = 2;
    localparam int          ST_LOADING     = 3;
    localparam int          ST_ENCRYPT     = 4;
    localparam int          ST_DECOMP      = 5;
    localparam int          ST_ENABLE      = 6;
    localparam int          ST_INIT        = 7;

    localparam int          DATA_W         = 32;
    localparam int          FIFO_DEPTH     = 8;
    localparam int          LINK_MODE_W    = 4;
    localparam logic [1:0]  CAP_WAIT       = 2'h2;

    typedef enum logic [1:0] {S_TRAIN, S_WAIT, S_LOAD, S_USER} load_state_t;
endpackage : fabric_load_pkg

// ==== hdl/load_fifo.sv ====
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset; DEPTH a power of two.
 */
module load_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   count;
    } fifo_t;

    fifo_t            s;
    fifo_t            next_s;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign in_ready_o  = (s.count != (AW+1)'(DEPTH));
    assign out_valid_o = (s.count != '0);
    assign out_data_o  = mem[s.rd];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.wr = s.wr + 1'b1;
        end
        if (pop) begin
            next_s.rd = s.rd + 1'b1;
        end
        next_s.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
        if (push) begin
            mem[s.wr] <= in_data_i;
        end
    end

    a_fifo_no_overflow: assert property (@(posedge clk_i) disable iff (rst_i)
        s.count <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule : load_fifo

// ==== hdl/fabric_image_loader.sv ====
/*
 * Fabric image loader behind the endpoint's vendor-specific capability.
 * Assumes config requests are held until CFG_ACK_O or CFG_RETRY_O, that the
 * control block drops CB_DONE_I within one cycle of CB_START_O, and that
 * CB_* and link signals share CLK_I; mode straps are asynchronous pins.
 */
module fabric_image_loader
    import fabric_load_pkg::*;
#(
    parameter logic [31:0] SILICON_ID = SILICON_ID_DEF
) (
    input  wire logic                   CLK_I,
    input  wire logic                   RST_I,
    input  wire logic                   MODE_ENABLE_I,
    input  wire logic                   MODE_INIT_I,
    input  wire logic                   COLD_RST_I,
    input  wire logic                   LINK_L0_I,
    input  wire logic [LINK_MODE_W-1:0] LINK_MODE_I,
    input  wire logic                   CFG_WR_I,
    input  wire logic                   CFG_RD_I,
    input  wire logic [2:0]             CFG_IDX_I,
    input  wire logic [DATA_W-1:0]      CFG_WDATA_I,
    input  wire logic                   MEM_WR_I,
    input  wire logic                   MEM_BAR_HIT_I,
    input  wire logic [DATA_W-1:0]      MEM_WDATA_I,
    input  wire logic                   CB_READY_I,
    input  wire logic                   CB_DONE_I,
    input  wire logic                   CB_ERROR_I,
    input  wire logic                   CB_ENCRYPT_I,
    input  wire logic                   CB_DECOMP_I,
    input  wire logic [15:0]            BOARD_TYPE_I,
    output logic                        CFG_ACK_O,
    output logic                        CFG_RETRY_O,
    output logic [DATA_W-1:0]           CFG_RDATA_O,
    output logic                        MEM_READY_O,
    output logic                        CB_START_O,
    output logic                        CB_VALID_O,
    output logic [DATA_W-1:0]           CB_DATA_O,
    output logic                        CORE_RUN_O,
    output logic                        LOAD_BAR_CLAIM_O,
    output logic                        APP_BAR_EN_O,
    output logic                        IO_FREEZE_O,
    output logic [LINK_MODE_W-1:0]      APP_LINK_MODE_O
);
    typedef struct packed {
        load_state_t            st;
        logic [1:0]             strap_a;
        logic [1:0]             strap_b;
        logic [1:0]             cap_cnt;
        logic                   cap_done;
        logic                   en_bit;
        logic                   init_bit;
        logic [LINK_MODE_W-1:0] link_mode;
        logic                   err;
        logic [31:0]            ctrl;
        logic [DATA_W-1:0]      data;
        logic                   ack;
        logic                   retry;
        logic [DATA_W-1:0]      rdata;
        logic                   cb_start;
        logic                   core_run;
    } loader_t;

    loader_t           s;
    loader_t           next_s;
    logic              loading;
    logic              user_mode;
    logic              retry_cond;
    logic              req;
    logic              take;
    logic              is_data_wr;
    logic              cfg_push;
    logic              mem_push;
    logic              fifo_in_ready;
    logic              fifo_empty;
    logic              ctrl_wr;
    logic [15:0]       status;
    logic [DATA_W-1:0] read_mux;

    assign loading    = (s.st == S_LOAD);
    assign user_mode  = (s.st == S_USER);
    assign retry_cond = !s.en_bit && !user_mode;
    assign req        = CFG_WR_I || CFG_RD_I;
    assign is_data_wr = CFG_WR_I && (CFG_IDX_I == IDX_DATA) && loading;
    // a data write waits for buffer room so the host is throttled, not dropped
    assign take       = req && !s.ack && !s.retry && (!is_data_wr || fifo_in_ready);
    assign cfg_push   = take && is_data_wr;
    assign mem_push   = MEM_WR_I && MEM_BAR_HIT_I && MEM_READY_O;
    assign MEM_READY_O = loading && fifo_in_ready && !cfg_push;
    assign ctrl_wr    = take && !retry_cond && CFG_WR_I && (CFG_IDX_I == IDX_CONTROL);

    always_comb begin
        status                = '0;
        status[ST_READY]      = loading && fifo_in_ready && !s.err;
        status[ST_ERROR]      = s.err;
        status[ST_USER]       = user_mode;
        status[ST_LOADING]    = loading;
        status[ST_ENCRYPT]    = CB_ENCRYPT_I;
        status[ST_DECOMP]     = CB_DECOMP_I;
        status[ST_ENABLE]     = s.en_bit;
        status[ST_INIT]       = s.init_bit;
    end

    // header words are constants: the core's own config space is never written
    always_comb begin
        read_mux = '0;
        if (CFG_IDX_I == IDX_CAP_HDR) begin
            read_mux = {CAP_NEXT, CAP_VERSION, CAP_ID_VSEC};
        end else if (CFG_IDX_I == IDX_LEN_REV_ID) begin
            read_mux = {VSEC_LEN, VSEC_REV, VSEC_ID};
        end else if (CFG_IDX_I == IDX_STATUS) begin
            read_mux = {16'h0000, status};
        end else if (CFG_IDX_I == IDX_CONTROL) begin
            read_mux = s.ctrl;
        end else if (CFG_IDX_I == IDX_SILICON) begin
            read_mux = SILICON_ID;
        end else if (CFG_IDX_I == IDX_BOARD) begin
            read_mux = {16'h0000, BOARD_TYPE_I};
        end
    end

    always_comb begin
        next_s          = s;
        next_s.strap_a  = {MODE_ENABLE_I, MODE_INIT_I};
        next_s.strap_b  = s.strap_a;
        next_s.ack      = 1'b0;
        next_s.retry    = 1'b0;
        next_s.cb_start = 1'b0;
        next_s.core_run = !COLD_RST_I;
        if (!s.cap_done) begin
            next_s.cap_cnt = s.cap_cnt + 2'h1;
            if (s.cap_cnt == CAP_WAIT) begin
                next_s.en_bit   = s.strap_b[1];
                next_s.init_bit = s.strap_b[0];
                next_s.cap_done = 1'b1;
            end
        end
        if (take) begin
            if (retry_cond) begin
                next_s.retry = 1'b1;
            end else begin
                next_s.ack = 1'b1;
                if (CFG_RD_I) begin
                    next_s.rdata = read_mux;
                end
            end
        end
        if (ctrl_wr) begin
            next_s.ctrl = CFG_WDATA_I & ~CTRL_STROBES;
        end
        if (cfg_push) begin
            next_s.data = CFG_WDATA_I;
        end else if (mem_push) begin
            next_s.data = MEM_WDATA_I;
        end
        case (s.st)
            S_TRAIN: begin
                if (LINK_L0_I && s.cap_done) begin
                    next_s.link_mode = LINK_MODE_I;
                    next_s.st        = CB_DONE_I ? S_USER : S_WAIT;
                end
            end
            S_WAIT: begin
                if (CB_DONE_I) begin
                    next_s.st = S_USER;
                end else if (ctrl_wr && CFG_WDATA_I[CTRL_START] && s.en_bit
                             && !s.init_bit) begin
                    next_s.st       = S_LOAD;
                    next_s.cb_start = 1'b1;
                    next_s.err      = 1'b0;
                end
            end
            S_LOAD: begin
                if (ctrl_wr && CFG_WDATA_I[CTRL_HALT]) begin
                    next_s.st = S_WAIT;
                end else if (CB_DONE_I && !s.cb_start && fifo_empty) begin
                    next_s.st = S_USER;
                end
            end
            S_USER: begin
                if (ctrl_wr && CFG_WDATA_I[CTRL_START] && s.en_bit) begin
                    next_s.st       = S_LOAD;
                    next_s.cb_start = 1'b1;
                    next_s.err      = 1'b0;
                end
            end
            default: begin
                next_s.st = S_TRAIN;
            end
        endcase
        // a new error beats a clear or a start in the same cycle
        if (CB_ERROR_I) begin
            next_s.err = 1'b1;
        end else if (ctrl_wr && CFG_WDATA_I[CTRL_ERR_CLR]) begin
            next_s.err = 1'b0;
        end
        // link drops but the fabric and its image are left as they are
        if (COLD_RST_I) begin
            next_s.st       = S_TRAIN;
            next_s.cb_start = 1'b0;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    load_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (CLK_I),
        .rst_i       (RST_I),
        .in_valid_i  (cfg_push || mem_push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (cfg_push ? CFG_WDATA_I : MEM_WDATA_I),
        .out_valid_o (CB_VALID_O),
        .out_ready_i (CB_READY_I),
        .out_data_o  (CB_DATA_O)
    );
    assign fifo_empty = !CB_VALID_O;

    assign CFG_ACK_O        = s.ack;
    assign CFG_RETRY_O      = s.retry;
    assign CFG_RDATA_O      = s.rdata;
    assign CB_START_O       = s.cb_start;
    assign CORE_RUN_O       = s.core_run;
    assign LOAD_BAR_CLAIM_O = loading;
    assign APP_BAR_EN_O     = !loading;
    assign IO_FREEZE_O      = loading;
    assign APP_LINK_MODE_O  = s.link_mode;

    default clocking cb_main @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    sequence data_taken;
        cfg_push;
    endsequence
    sequence start_written;
        ctrl_wr && CFG_WDATA_I[CTRL_START] && s.en_bit && (s.st == S_USER) && !COLD_RST_I;
    endsequence
    sequence halt_written;
        ctrl_wr && CFG_WDATA_I[CTRL_HALT] && loading && !COLD_RST_I;
    endsequence

    a_core_autonomous: assert property (!COLD_RST_I |=> CORE_RUN_O)
        else $error("core not running outside cold reset");
    a_load_after_l0: assert property ($rose(loading) |-> $past(s.st) != S_TRAIN)
        else $error("load began before link reached L0");
    a_mode_held: assert property ((s.st != S_TRAIN) && ($past(s.st) != S_TRAIN)
        |-> $stable(APP_LINK_MODE_O))
        else $error("link mode changed after training");
    a_data_stored: assert property (data_taken |=> CFG_ACK_O && s.data == $past(CFG_WDATA_I))
        else $error("data write not stored and acknowledged");
    a_error_sticky: assert property (CB_ERROR_I |=> status[ST_ERROR] [*2])
        else $error("error flag did not stay set");
    a_silicon_read: assert property (take && CFG_RD_I && !retry_cond && CFG_IDX_I == IDX_SILICON
        |=> CFG_ACK_O && CFG_RDATA_O == SILICON_ID)
        else $error("silicon identity read wrong");
    a_reload_start: assert property (start_written
        |=> CB_START_O && LOAD_BAR_CLAIM_O && !APP_BAR_EN_O)
        else $error("user-mode start did not re-enter loading");
    a_cold_no_load: assert property (COLD_RST_I |=> !CB_START_O && s.st == S_TRAIN ##1 !loading)
        else $error("cold reset started a load");
    a_retry_off: assert property (take && retry_cond |=> CFG_RETRY_O && !CFG_ACK_O)
        else $error("no retry while loading is off");
    a_load_enabled: assert property ($rose(loading) |-> s.en_bit)
        else $error("load entered with loading disabled");

    // the pulse and the state are set on the same edge, so a start never lands outside a load
    a_start_in_load: assert property (CB_START_O |-> LOAD_BAR_CLAIM_O && IO_FREEZE_O)
        else $error("start pulse outside loading");
    a_halt_leaves: assert property (halt_written |=> !loading && !CB_START_O)
        else $error("halt did not leave loading");
    a_user_on_done: assert property ($rose(user_mode) |-> $past(CB_DONE_I))
        else $error("user mode without control block done");
    a_retry_no_write: assert property (take && retry_cond |=> $stable(s.ctrl))
        else $error("retried request changed control");
    a_ack_pulse: assert property (CFG_ACK_O |=> !CFG_ACK_O)
        else $error("acknowledge stood longer than one cycle");
    a_straps_fixed: assert property (s.cap_done && $past(s.cap_done)
        |-> $stable(s.en_bit) && $stable(s.init_bit))
        else $error("mode bits changed after capture");
    a_mode_from_train: assert property ($changed(APP_LINK_MODE_O)
        |-> $past(s.st) == S_TRAIN)
        else $error("link mode changed outside training");
    a_cold_core_down: assert property (COLD_RST_I |=> !CORE_RUN_O)
        else $error("core still running in cold reset");
    // a full buffer must throttle the host rather than drop a word
    a_full_throttles: assert property (!fifo_in_ready |-> !MEM_READY_O && !cfg_push)
        else $error("word offered to a full buffer");
    a_clear_error: assert property (ctrl_wr && CFG_WDATA_I[CTRL_ERR_CLR] && !CB_ERROR_I
        |=> !status[ST_ERROR])
        else $error("error clear ignored");
endmodule : fabric_image_loader

// ==== tb/cb_model.sv ====
/*
 * Behavioural model of the configuration control block that programs the fabric.
 * Assumes the loader's stream port on the same clock; the bench sets stall and length.
 */
module cb_model
    import fabric_load_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              start_i,
    input  wire logic              valid_i,
    input  wire logic [DATA_W-1:0] data_i,
    input  wire logic              stall_i,
    input  wire logic              preset_i,
    input  wire logic [7:0]        want_i,
    output logic                   ready_o,
    output logic                   done_o,
    output logic [7:0]             got_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] words [16];

    // stalls whenever the bench asks, no kinder than a busy control block
    assign ready_o = !stall_i && !rst_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            got_o  <= 8'h00;
            done_o <= 1'b0;
        end else begin
            if (valid_i && ready_o) begin
                words[got_o[3:0]] <= data_i;
                got_o             <= got_o + 8'h01;
            end
            // a new load restarts the count and leaves user mode at once
            if (start_i) begin
                got_o  <= 8'h00;
                done_o <= 1'b0;
            end else if (preset_i || (want_i != 8'h00 && got_o == want_i)) begin
                done_o <= 1'b1;
            end
        end
    end
endmodule : cb_model

// ==== tb/tb_top.sv ====
/*
 * Self-checking bench for the fabric image loader, host side driven by tasks.
 * Assumes the loader and its fifo compiled with the package; control block is cb_model.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fabric_load_pkg::*;
    localparam logic [31:0] SIL = 32'h0000_00A5; // arbitrary value

    logic CLK_I = 0, RST_I = 1, MODE_ENABLE_I = 0, MODE_INIT_I = 0, COLD_RST_I = 0;
    logic LINK_L0_I = 0, CFG_WR_I = 0, CFG_RD_I = 0, MEM_WR_I = 0, MEM_BAR_HIT_I = 0;
    logic CB_ERROR_I = 0, CB_ENCRYPT_I = 0, CB_DECOMP_I = 0, stall = 0, preset = 0;
    logic [LINK_MODE_W-1:0] LINK_MODE_I = 4'h6;
    logic [2:0]             CFG_IDX_I = 3'h0;
    logic [31:0]            CFG_WDATA_I = 32'h0000_0000, MEM_WDATA_I = 32'h0000_0000;
    logic [15:0]            BOARD_TYPE_I = 16'h5A3C;
    logic [7:0]             want = 8'h00, got;
    logic CB_READY_I, CB_DONE_I, CFG_ACK_O, CFG_RETRY_O, MEM_READY_O, CB_START_O, CB_VALID_O;
    logic CORE_RUN_O, LOAD_BAR_CLAIM_O, APP_BAR_EN_O, IO_FREEZE_O;
    logic [31:0]            CFG_RDATA_O, CB_DATA_O;
    logic [LINK_MODE_W-1:0] APP_LINK_MODE_O;
    int error_cnt = 0, comparisons = 0, start_cnt = 0, n;

    always #2 CLK_I = ~CLK_I;
    // counted mid-cycle so a check at the answer edge already sees the pulse
    always @(negedge CLK_I) if (CB_START_O === 1'b1) start_cnt++;

    fabric_image_loader #(.SILICON_ID(SIL)) fabric_image_loader_inst (
        .CLK_I(CLK_I), .RST_I(RST_I), .MODE_ENABLE_I(MODE_ENABLE_I), .MODE_INIT_I(MODE_INIT_I),
        .COLD_RST_I(COLD_RST_I), .LINK_L0_I(LINK_L0_I), .LINK_MODE_I(LINK_MODE_I),
        .CFG_WR_I(CFG_WR_I), .CFG_RD_I(CFG_RD_I), .CFG_IDX_I(CFG_IDX_I),
        .CFG_WDATA_I(CFG_WDATA_I), .MEM_WR_I(MEM_WR_I), .MEM_BAR_HIT_I(MEM_BAR_HIT_I),
        .MEM_WDATA_I(MEM_WDATA_I), .CB_READY_I(CB_READY_I), .CB_DONE_I(CB_DONE_I),
        .CB_ERROR_I(CB_ERROR_I), .CB_ENCRYPT_I(CB_ENCRYPT_I), .CB_DECOMP_I(CB_DECOMP_I),
        .BOARD_TYPE_I(BOARD_TYPE_I), .CFG_ACK_O(CFG_ACK_O), .CFG_RETRY_O(CFG_RETRY_O),
        .CFG_RDATA_O(CFG_RDATA_O), .MEM_READY_O(MEM_READY_O), .CB_START_O(CB_START_O),
        .CB_VALID_O(CB_VALID_O), .CB_DATA_O(CB_DATA_O), .CORE_RUN_O(CORE_RUN_O),
        .LOAD_BAR_CLAIM_O(LOAD_BAR_CLAIM_O), .APP_BAR_EN_O(APP_BAR_EN_O),
        .IO_FREEZE_O(IO_FREEZE_O), .APP_LINK_MODE_O(APP_LINK_MODE_O));

    cb_model cb_model_inst (
        .clk_i(CLK_I), .rst_i(RST_I), .start_i(CB_START_O), .valid_i(CB_VALID_O),
        .data_i(CB_DATA_O), .stall_i(stall), .preset_i(preset), .want_i(want),
        .ready_o(CB_READY_I), .done_o(CB_DONE_I), .got_o(got));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // request held until the answer edge, dropped there, never re-raised on that edge
    task automatic cfg(input logic wr, input logic [2:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic rt);
        int k;
        @(posedge CLK_I);
        CFG_WR_I <= wr;
        CFG_RD_I <= !wr;
        CFG_IDX_I <= idx;
        CFG_WDATA_I <= wd;
        k = 0;
        do begin
            @(posedge CLK_I);
            k++;
        end while (!(CFG_ACK_O === 1'b1 || CFG_RETRY_O === 1'b1) && k < 300);
        check("cfg_answer", 32'(k < 300), 32'h1);
        rd = CFG_RDATA_O;
        rt = CFG_RETRY_O;
        CFG_WR_I <= 1'b0;
        CFG_RD_I <= 1'b0;
    endtask : cfg

    task automatic wr(input logic [2:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic rt;
        cfg(1'b1, idx, d, r, rt);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [2:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        logic rt;
        cfg(1'b0, idx, 32'h0000_0000, r, rt);
        check(nm, r, exp);
    endtask : rd_chk

    task automatic st_chk(input string nm, input int b, input logic exp);
        logic [31:0] r;
        logic rt;
        cfg(1'b0, IDX_STATUS, 32'h0000_0000, r, rt);
        check(nm, 32'(r[b]), 32'(exp));
    endtask : st_chk

    // pushes counting words until max or six refused beats in a row
    task automatic mem_fill(input int max, output int took);
        int idle;
        took = 0;
        idle = 0;
        @(posedge CLK_I);
        MEM_WR_I <= 1'b1;
        MEM_BAR_HIT_I <= 1'b1;
        MEM_WDATA_I <= 32'hC0DE_0000;
        while (idle < 6 && took < max) begin
            @(posedge CLK_I);
            if (MEM_READY_O === 1'b1) begin
                took++;
                idle = 0;
                MEM_WDATA_I <= 32'hC0DE_0000 + took;
            end else idle++;
        end
        MEM_WR_I <= 1'b0;
        MEM_BAR_HIT_I <= 1'b0;
    endtask : mem_fill

    task automatic do_reset(input logic en, input logic ini, input logic l0);
        @(posedge CLK_I);
        RST_I <= 1'b1;
        MODE_ENABLE_I <= en;
        MODE_INIT_I <= ini;
        LINK_L0_I <= l0;
        repeat (12) @(posedge CLK_I);
        RST_I <= 1'b0;
        repeat (6) @(posedge CLK_I);
    endtask : do_reset

    task automatic print_verdict();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict

    initial begin
        #60000;
        error_cnt++;
        print_verdict();
    end

    initial begin
        logic [31:0] r;
        logic rt;
        do_reset(1'b0, 1'b1, 1'b1);
        check("core_run", 32'(CORE_RUN_O), 32'h1);
        cfg(1'b0, IDX_STATUS, 32'h0000_0000, r, rt);
        check("retry", 32'(rt), 32'h1);
        do_reset(1'b1, 1'b0, 1'b0);
        wr(IDX_CONTROL, 32'h0000_0001);
        check("start_before_l0", start_cnt, 0);
        @(posedge CLK_I);
        LINK_L0_I <= 1'b1;
        repeat (4) @(posedge CLK_I);
        LINK_MODE_I <= 4'h3;
        rd_chk("cap_hdr", IDX_CAP_HDR, {CAP_NEXT, CAP_VERSION, CAP_ID_VSEC});
        rd_chk("vsec_hdr", IDX_LEN_REV_ID, {VSEC_LEN, VSEC_REV, VSEC_ID});
        rd_chk("silicon", IDX_SILICON, SIL);
        rd_chk("board", IDX_BOARD, {16'h0000, BOARD_TYPE_I});
        check("link_mode", 32'(APP_LINK_MODE_O), 32'h6);
        st_chk("st_enable", ST_ENABLE, 1'b1);
        st_chk("st_init", ST_INIT, 1'b0);
        want <= 8'h0A;
        stall <= 1'b1;
        CB_ENCRYPT_I <= 1'b1;
        wr(IDX_CONTROL, 32'h1234_5671);
        check("start", start_cnt, 1);
        rd_chk("control", IDX_CONTROL, 32'h1234_5670);
        st_chk("loading", ST_LOADING, 1'b1);
        st_chk("encrypt", ST_ENCRYPT, 1'b1);
        st_chk("decomp", ST_DECOMP, 1'b0);
        check("bars_io", 32'({LOAD_BAR_CLAIM_O, APP_BAR_EN_O, IO_FREEZE_O}), 32'h5);
        @(posedge CLK_I);
        CB_ERROR_I <= 1'b1;
        @(posedge CLK_I);
        CB_ERROR_I <= 1'b0;
        st_chk("error", ST_ERROR, 1'b1);
        wr(IDX_CONTROL, 32'h1234_5674);
        st_chk("error_clr", ST_ERROR, 1'b0);
        mem_fill(10, n);
        check("fifo_fill", n, FIFO_DEPTH);
        st_chk("full_busy", ST_READY, 1'b0);
        stall <= 1'b0;
        CB_DECOMP_I <= 1'b1;
        repeat (12) @(posedge CLK_I);
        st_chk("ready", ST_READY, 1'b1);
        st_chk("decomp_on", ST_DECOMP, 1'b1);
        wr(IDX_DATA, 32'hC0DE_0008);
        wr(IDX_DATA, 32'hC0DE_0009);
        for (int k = 0; k < 100 && APP_BAR_EN_O !== 1'b1; k++) @(posedge CLK_I);
        check("got", 32'(got), 32'h0A);
        for (int i = 0; i < 10; i++) check("word", cb_model_inst.words[i], 32'hC0DE_0000 + i);
        st_chk("user", ST_USER, 1'b1);
        mem_fill(1, n);
        check("mem_refused", n, 0);
        wr(IDX_CONTROL, 32'h0000_0001);
        check("reload", start_cnt, 2);
        wr(IDX_CONTROL, 32'h0000_0002);
        st_chk("halt", ST_LOADING, 1'b0);
        @(posedge CLK_I);
        COLD_RST_I <= 1'b1;
        repeat (3) @(posedge CLK_I);
        check("cold_down", 32'(CORE_RUN_O), 32'h0);
        COLD_RST_I <= 1'b0;
        repeat (8) @(posedge CLK_I);
        check("cold_no_start", start_cnt, 2);
        check("core_back", 32'(CORE_RUN_O), 32'h1);
        preset <= 1'b1;
        do_reset(1'b1, 1'b1, 1'b1);
        preset <= 1'b0;
        st_chk("update_user", ST_USER, 1'b1);
        wr(IDX_CONTROL, 32'h0000_0001);
        check("update_start", start_cnt, 3);
        print_verdict();
    end
endmodule : tb_top
